/* File: src/adc_chop_params.svh */
/*
  Timing counts, command codes and field decodes for the chop, standby and
  current-detect sequencer. Assumes a 10 MHz system clock.
*/
`ifndef ADC_CHOP_PARAMS_SVH
`define ADC_CHOP_PARAMS_SVH

`define CLOCK_NS 100
`define CMD_STANDBY 16'h0022
`define CMD_RESUME 16'h0033
`define CMD_BITS 5'h10
`define FIRST_EXTRA_TICKS 18'h2c
`define WAKE_TICKS 4'h8
`define CHOP_DELAY_BASE 17'h2
`define CONV_PER_RESULT 3
`define DETECT_RATE_SPS 2700
`define DETECT_TICK_CYCLES ((1000000000 / `CLOCK_NS) / `DETECT_RATE_SPS)
`define RESET_QUALIFY_NS 2000
`define RESET_QUALIFY_CYCLES ((`RESET_QUALIFY_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define READY_LOW_CYCLES 4'h4
`define DET_LEN0 12'h080
`define DET_LEN1 12'h100
`define DET_LEN2 12'h200
`define DET_LEN3 12'h300
`define DET_LEN4 12'h400
`define DET_LEN5 12'h600
`define DET_LEN6 12'h800
`define DET_LEN7 12'he00
`define PIN_SYNC_INIT 5'h0a

`endif

/* File: src/adc_chop_pkg.sv */
/*
  Types shared by the sequencer: top-level modes, chop phases, power levels.
  Assumes the constants header is included where numbers are needed.
*/
package adc_chop_pkg;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_STANDBY = 5'h02,
    ST_WAKE = 5'h04,
    ST_DETECT = 5'h08,
    ST_RESET = 5'h10
  } mode_t;
  typedef enum logic [2:0] {
    PH_FIRST = 3'h1,
    PH_DELAY = 3'h2,
    PH_CONV = 3'h4
  } chop_phase_t;
  typedef enum logic [2:0] {
    high_resolution_level = 3'h1,
    low_power_level = 3'h2,
    very_low_power_level = 3'h4
  } power_t;
endpackage

/* File: src/pin_sync.sv */
/*
  Two-flop synchroniser for a group of pins.
  Assumes every bit is an independent level from outside the clock domain.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pins in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;
  sync_state_t q;
  sync_state_t nxt_q;

  always_comb begin
    nxt_q = q;
    nxt_q.s1 = async_in;
    nxt_q.s2 = q.s1;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= {INIT, INIT};
    end else begin
      q <= nxt_q;
    end
  end

  assign sync_out = q.s2;
endmodule

/* File: src/chop_avg.sv */
/*
  Pairs two chop conversions per channel into an offset-free result, or
  passes a plain conversion through. Assumes go is a one-cycle strobe.
*/
`timescale 1ns/1ps
module chop_avg #(
  parameter int CH = 4,
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Request
  input wire logic go,
  input wire logic pass,
  input wire logic cur_reversed,
  input wire logic [CH*W-1:0] prev,
  input wire logic [CH*W-1:0] cur,
  // Result
  output logic [CH*W-1:0] result,
  output logic valid
);
  typedef struct packed {
    logic [CH*W-1:0] result;
    logic valid;
  } avg_state_t;
  avg_state_t q;
  avg_state_t nxt_q;
  logic [CH*W-1:0] avg_w;

  genvar i;
  generate
    for (i = 0; i < CH; i++) begin : g_ch
      logic signed [W:0] a;
      logic signed [W:0] b;
      logic signed [W:0] diff;
      assign a = {prev[i*W+W-1], prev[i*W +: W]};
      assign b = {cur[i*W+W-1], cur[i*W +: W]};
      // Normal minus reversed cancels the inner offset
      assign diff = cur_reversed ? (a - b) : (b - a);
      assign avg_w[i*W +: W] = diff[W:1];
    end
  endgenerate

  always_comb begin
    nxt_q = q;
    nxt_q.valid = go;
    if (go) begin
      nxt_q.result = pass ? cur : avg_w;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  assign result = q.result;
  assign valid = q.valid;
endmodule

/* File: src/adc_chop_standby_detect_ctrl.sv */
/*
  Conversion-mode sequencer of a four-channel delta-sigma converter: chop
  timing and averaging, power level, standby by command and current detect.
  Assumes the filter presents conversion data on conv_data, pins are async,
  and the modulator period is one period of converter_clock_in.
*/
`timescale 1ns/1ps
`include "adc_chop_params.svh"
module adc_chop_standby_detect_ctrl import adc_chop_pkg::*; #(
  parameter int CH = 4,
  parameter int W = 24,
  parameter int RESET_QUALIFY_CYCLES = `RESET_QUALIFY_CYCLES,
  parameter int DETECT_TICK_CYCLES = `DETECT_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pins
  input wire logic converter_clock_in,
  input wire logic sync_reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  output logic data_ready_n,
  // Configuration
  input wire logic chop_enable,
  input wire logic [3:0] chop_settle_delay,
  input wire logic [14:0] oversampling_ratio,
  input wire logic [1:0] power_level_select,
  input wire logic dc_test_request,
  input wire logic detect_enable,
  input wire logic [15:0] threshold_high_reg,
  input wire logic [7:0] threshold_low_reg,
  input wire logic [2:0] detect_sample_count,
  input wire logic [2:0] detect_hit_count,
  input wire logic detect_all_channels,
  input wire logic [CH-1:0] channel_enable,
  // Filter side
  input wire logic conv_valid,
  input wire logic [CH*W-1:0] conv_data,
  output logic input_polarity,
  output logic filter_reset,
  // Results and status
  output logic [CH*W-1:0] chop_result,
  output logic result_valid,
  output logic phase_cal_enable,
  output logic dc_test_select,
  output logic [2:0] power_mode,
  output logic [CH-1:0] channel_on,
  output logic osc_enable,
  output logic device_in_reset
);
  typedef struct packed {
    mode_t st;
    chop_phase_t ph;
    logic [17:0] cnt;
    logic pol;
    logic frst;
    logic have_prev;
    logic [CH*W-1:0] prev;
    logic [3:0] wcnt;
    logic [14:0] ratio_q;
    logic [15:0] qual;
    logic mclk_d;
    logic sync_d;
    logic sclk_d;
    logic cs_d;
    logic [15:0] cmd_sr;
    logic [4:0] bitcnt;
    logic [15:0] resp_sr;
    logic dout;
    logic [3:0] ready_cnt;
    logic ready_n;
    logic [11:0] dtick;
    logic [11:0] dsamp;
    logic [CH-1:0][2:0] hits;
    power_t power;
    logic phase_cal;
    logic dc_test;
  } ctrl_state_t;
  ctrl_state_t q;
  ctrl_state_t nxt_q;

  logic [4:0] pin_s;
  logic mclk_s, sync_s, sclk_s, cs_s, din_s;
  logic avg_go, avg_pass;
  logic [CH-1:0] over, met;
  logic [CH-1:0][2:0] hit_nxt;
  logic [23:0] detect_threshold;
  logic [3:0] need;
  logic det_met;
  logic [16:0] dly_len, conv_len;
  logic [11:0] det_len;

  pin_sync #(.W(5), .INIT(`PIN_SYNC_INIT)) u_pins (
    .clock(clock),
    .rstn(rstn),
    .async_in({converter_clock_in, sync_reset_n, sclk, cs_n, din}),
    .sync_out(pin_s)
  );
  assign {mclk_s, sync_s, sclk_s, cs_s, din_s} = pin_s;

  chop_avg #(.CH(CH), .W(W)) u_avg (
    .clock(clock),
    .rstn(rstn),
    .go(avg_go),
    .pass(avg_pass),
    .cur_reversed(q.pol),
    .prev(q.prev),
    .cur(conv_data),
    .result(chop_result),
    .valid(result_valid)
  );

  assign detect_threshold = {threshold_high_reg, threshold_low_reg};
  assign need = {1'b0, detect_hit_count} + 4'h1;
  assign dly_len = `CHOP_DELAY_BASE << chop_settle_delay;
  assign conv_len = 17'(`CONV_PER_RESULT * oversampling_ratio);

  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_det
      logic [W-1:0] mag;
      assign mag = conv_data[c*W+W-1] ? -conv_data[c*W +: W] : conv_data[c*W +: W];
      assign over[c] = channel_enable[c] & (mag > detect_threshold);
      assign hit_nxt[c] = (over[c] && q.hits[c] != 3'h7) ? q.hits[c] + 3'h1 : q.hits[c];
      assign met[c] = {1'b0, q.hits[c]} >= need;
    end
  endgenerate

  // All enabled channels, or any one of them
  assign det_met = detect_all_channels ? (&(met | ~channel_enable)) & (|channel_enable)
                                       : |(met & channel_enable);

  always_comb begin
    case (detect_sample_count)
      3'h0: det_len = `DET_LEN0;
      3'h1: det_len = `DET_LEN1;
      3'h2: det_len = `DET_LEN2;
      3'h3: det_len = `DET_LEN3;
      3'h4: det_len = `DET_LEN4;
      3'h5: det_len = `DET_LEN5;
      3'h6: det_len = `DET_LEN6;
      default: det_len = `DET_LEN7;
    endcase
  end

  always_comb begin
    logic tick, sync_fall, sync_rise, long_low, frame_end, restart, ready_evt;
    tick = mclk_s & ~q.mclk_d;
    sync_fall = q.sync_d & ~sync_s;
    sync_rise = ~q.sync_d & sync_s;
    long_low = q.qual >= 16'(RESET_QUALIFY_CYCLES);
    frame_end = cs_s & ~q.cs_d & (q.bitcnt == `CMD_BITS);
    restart = 1'b0;
    ready_evt = 1'b0;
    avg_go = 1'b0;
    avg_pass = 1'b0;
    nxt_q = q;
    nxt_q.frst = 1'b0;
    nxt_q.mclk_d = mclk_s;
    nxt_q.sync_d = sync_s;
    nxt_q.sclk_d = sclk_s;
    nxt_q.cs_d = cs_s;
    nxt_q.ratio_q = oversampling_ratio;
    nxt_q.phase_cal = ~chop_enable;
    nxt_q.dc_test = dc_test_request & ~chop_enable;
    case (power_level_select)
      2'h1: nxt_q.power = low_power_level;
      2'h2, 2'h3: nxt_q.power = very_low_power_level;
      default: nxt_q.power = high_resolution_level;
    endcase
    // Shift on falling sclk, launch on rising
    if (!cs_s) begin
      if (q.sclk_d && !sclk_s && q.bitcnt != `CMD_BITS) begin
        nxt_q.cmd_sr = {q.cmd_sr[14:0], din_s};
        nxt_q.bitcnt = q.bitcnt + 5'h1;
      end
      if (!q.sclk_d && sclk_s) begin
        nxt_q.dout = q.resp_sr[15];
        nxt_q.resp_sr = {q.resp_sr[14:0], 1'b0};
      end
    end else begin
      nxt_q.bitcnt = 5'h0;
      nxt_q.resp_sr = {11'h0, q.st};
    end
    if (!sync_s) begin
      nxt_q.qual = (q.qual == 16'hffff) ? q.qual : q.qual + 16'h1;
    end else begin
      nxt_q.qual = 16'h0;
    end
    case (q.st)
      ST_RUN: begin
        if (frame_end && q.cmd_sr == `CMD_STANDBY) begin
          nxt_q.st = ST_STANDBY;
        end else if (sync_fall || oversampling_ratio != q.ratio_q) begin
          restart = 1'b1;
        end else if (!chop_enable) begin
          nxt_q.ph = PH_FIRST;
          nxt_q.cnt = 18'h0;
          nxt_q.pol = 1'b0;
          nxt_q.have_prev = 1'b0;
          avg_go = conv_valid;
          avg_pass = 1'b1;
        end else if (tick) begin
          nxt_q.cnt = q.cnt + 18'h1;
          case (q.ph)
            PH_FIRST: begin
              if (q.cnt == `FIRST_EXTRA_TICKS - 18'h1) begin
                nxt_q.ph = PH_DELAY;
                nxt_q.cnt = 18'h0;
              end
            end
            PH_DELAY: begin
              if (q.cnt == {1'b0, dly_len - 17'h1}) begin
                nxt_q.ph = PH_CONV;
                nxt_q.cnt = 18'h0;
              end
            end
            PH_CONV: begin
              if (q.cnt == {1'b0, conv_len - 17'h1}) begin
                avg_go = q.have_prev;
                nxt_q.prev = conv_data;
                nxt_q.have_prev = 1'b1;
                nxt_q.pol = ~q.pol;
                nxt_q.frst = 1'b1;
                nxt_q.ph = PH_DELAY;
                nxt_q.cnt = 18'h0;
              end
            end
            default: nxt_q.ph = PH_FIRST;
          endcase
        end
      end
      ST_STANDBY: begin
        if (frame_end && q.cmd_sr == `CMD_RESUME) begin
          nxt_q.st = ST_WAKE;
          nxt_q.wcnt = 4'h0;
        end else if (sync_rise && !long_low && detect_enable) begin
          nxt_q.st = ST_DETECT;
          nxt_q.dtick = 12'h0;
          nxt_q.dsamp = 12'h0;
          nxt_q.hits = '0;
        end
      end
      ST_WAKE: begin
        if (tick) begin
          nxt_q.wcnt = q.wcnt + 4'h1;
          if (q.wcnt == `WAKE_TICKS - 4'h1) begin
            nxt_q.st = ST_RUN;
            restart = 1'b1;
          end
        end
      end
      ST_DETECT: begin
        if (!detect_enable) begin
          nxt_q.st = ST_STANDBY;
        end else if (det_met) begin
          nxt_q.st = ST_STANDBY;
          ready_evt = 1'b1;
        end else if (q.dtick == 12'(DETECT_TICK_CYCLES - 1)) begin
          nxt_q.dtick = 12'h0;
          nxt_q.hits = hit_nxt;
          nxt_q.dsamp = q.dsamp + 12'h1;
          if (q.dsamp == det_len - 12'h1) begin
            nxt_q.dsamp = 12'h0;
            nxt_q.hits = '0;
          end
        end else begin
          nxt_q.dtick = q.dtick + 12'h1;
        end
      end
      ST_RESET: begin
        if (sync_s) begin
          nxt_q.st = ST_RUN;
          restart = 1'b1;
        end
      end
      default: nxt_q.st = ST_RUN;
    endcase
    if (restart) begin
      nxt_q.ph = PH_FIRST;
      nxt_q.cnt = 18'h0;
      nxt_q.pol = 1'b0;
      nxt_q.have_prev = 1'b0;
      nxt_q.frst = 1'b1;
    end
    if (long_low) begin
      nxt_q.st = ST_RESET;
      nxt_q.have_prev = 1'b0;
      avg_go = 1'b0;
    end
    // Low for a few cycles per event
    if (result_valid || ready_evt) begin
      nxt_q.ready_n = 1'b0;
      nxt_q.ready_cnt = `READY_LOW_CYCLES - 4'h1;
    end else if (q.ready_cnt != 4'h0) begin
      nxt_q.ready_cnt = q.ready_cnt - 4'h1;
    end else begin
      nxt_q.ready_n = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
      q.st <= ST_RUN;
      q.ph <= PH_FIRST;
      q.sync_d <= 1'b1;
      q.cs_d <= 1'b1;
      q.ready_n <= 1'b1;
      q.power <= high_resolution_level;
      q.phase_cal <= 1'b1;
    end else begin
      q <= nxt_q;
    end
  end

  assign dout = q.dout;
  assign dout_oe_n = q.cs_d;
  assign data_ready_n = q.ready_n;
  assign input_polarity = q.pol;
  assign filter_reset = q.frst;
  assign phase_cal_enable = q.phase_cal;
  assign dc_test_select = q.dc_test;
  assign power_mode = q.power;
  assign channel_on = (q.st == ST_RUN) ? {CH{1'b1}} :
                      (q.st == ST_DETECT) ? channel_enable : '0;
  assign osc_enable = (q.st == ST_DETECT);
  assign device_in_reset = (q.st == ST_RESET);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_ready_on_result;
    result_valid |=> !data_ready_n [*4] ##1 data_ready_n;
  endproperty
  a_ready_on_result: assert property (p_ready_on_result) else $error("ready not low");

  property p_swap_resets_filter;
    (q.st == ST_RUN) && $changed(input_polarity) |-> filter_reset;
  endproperty
  a_swap_resets_filter: assert property (p_swap_resets_filter) else $error("no reset");

  property p_phase_cal_off;
    chop_enable ##1 chop_enable |-> !phase_cal_enable;
  endproperty
  a_phase_cal_off: assert property (p_phase_cal_off) else $error("phase cal on");

  property p_dc_test_blocked;
    chop_enable ##1 chop_enable |-> !dc_test_select;
  endproperty
  a_dc_test_blocked: assert property (p_dc_test_blocked) else $error("dc test on");

  property p_standby_cmd;
    (q.st == ST_RUN) && cs_s && !q.cs_d && q.bitcnt == `CMD_BITS
      && q.cmd_sr == `CMD_STANDBY && !(q.qual >= 16'(RESET_QUALIFY_CYCLES))
      |=> channel_on == '0 && q.st == ST_STANDBY;
  endproperty
  a_standby_cmd: assert property (p_standby_cmd) else $error("standby missed");

  property p_wake_eight;
    (q.st == ST_WAKE) && $rose(q.st == ST_WAKE) |-> (q.st == ST_WAKE) [*8];
  endproperty
  a_wake_eight: assert property (p_wake_eight) else $error("wake too early");

  logic sync_fall_w;
  assign sync_fall_w = q.sync_d & ~sync_s & ~(q.qual >= 16'(RESET_QUALIFY_CYCLES));
  property p_restart;
    (q.st == ST_RUN) && sync_fall_w |=> q.ph == PH_FIRST && q.cnt == 18'h0 && !q.have_prev;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_detect_hidden;
    (q.st == ST_DETECT) |=> !result_valid && $stable(chop_result);
  endproperty
  a_detect_hidden: assert property (p_detect_hidden) else $error("result leaked");

  property p_detect_notify;
    (q.st == ST_DETECT) && det_met && detect_enable
      && !(q.qual >= 16'(RESET_QUALIFY_CYCLES)) |=> q.st == ST_STANDBY ##1 !data_ready_n;
  endproperty
  a_detect_notify: assert property (p_detect_notify) else $error("no notify");

  property p_first_wait;
    (q.st == ST_RUN) && $rose(q.ph == PH_DELAY) && !q.have_prev |-> $past(q.cnt) == 18'h2b;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("first wait wrong");

  c_result: cover property (result_valid && chop_enable);
  c_detect_hit: cover property ((q.st == ST_DETECT) ##1 (q.st == ST_STANDBY) && !data_ready_n);
  c_wake: cover property ((q.st == ST_WAKE) ##1 (q.st == ST_RUN));
  c_reset: cover property (device_in_reset);
endmodule

/* File: verif/host_serial_ctrl.sv */
/*
  Host-side model: frames 16-bit commands on the serial pins and pulses sync.
  Assumes the device samples din on sclk falls and times pins off clock.
*/
`timescale 1ns/1ps
module host_serial_ctrl (
  // Clock
  input wire logic clock,
  // Serial and sync pins
  input wire logic dout,
  output logic sclk,
  output logic cs_n,
  output logic din,
  output logic sync_reset_n
);
  // Response word seen on dout during the last frame
  logic [15:0] resp;

  initial begin
    resp = 16'h0;
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
    sync_reset_n = 1'b1;
  end

  // Sclk stands low outside frames; din changes on rises, then flips once after cs_n rises
  task automatic send_cmd(input logic [15:0] cmd);
    cs_n = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      din = cmd[i];
      #400;
      sclk = 1'b0;
      resp = {resp[14:0], dout};
      #400;
    end
    cs_n = 1'b1;
    din = ~din;
  endtask

  // Short pulse syncs or enters detect; long one resets
  task automatic sync_pulse(input int n);
    @(posedge clock) #1 sync_reset_n = 1'b0;
    repeat (n) @(posedge clock);
    #1 sync_reset_n = 1'b1;
  endtask
endmodule

/* File: verif/test_adc_chop_standby_detect_ctrl.sv */
/*
  Self-checking bench for the chop, standby and current-detect sequencer.
  Assumes host_serial_ctrl drives the serial and sync pins.
*/
`timescale 1ns/1ps
module test_adc_chop_standby_detect_ctrl;
  import adc_chop_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic converter_clock_in = 1'b0;
  logic chop_enable = 1'b0;
  logic [3:0] chop_settle_delay = 4'h1;
  logic [14:0] oversampling_ratio = 15'h0005;
  logic [1:0] power_level_select = 2'h0;
  logic dc_test_request = 1'b1;
  logic detect_enable = 1'b1;
  logic [15:0] threshold_high_reg = 16'h0001;
  logic [7:0] threshold_low_reg = 8'h00;
  logic [2:0] detect_sample_count = 3'h0;
  logic [2:0] detect_hit_count = 3'h2;
  logic detect_all_channels = 1'b0;
  logic [3:0] channel_enable = 4'h3;
  logic conv_valid = 1'b0;
  logic pol_mode = 1'b0;
  logic [95:0] raw = 96'h0;
  logic [95:0] norm, rev, exp_chop;
  logic [31:0] seed = 32'h0000002a;
  logic pol0;
  int err_total = 0;
  int total_checks = 0;
  int ticks = 0;
  int fr_cnt = 0;
  int n, fr0, a, o;
  logic [95:0] exp_q[$];
  wire logic sclk, cs_n, din, sync_reset_n, dout, dout_oe_n, data_ready_n;
  wire logic input_polarity, filter_reset, result_valid, phase_cal_enable;
  wire logic dc_test_select, osc_enable, device_in_reset;
  wire logic [95:0] chop_result;
  wire logic [2:0] power_mode;
  wire logic [3:0] channel_on;
  // Filter stand-in: with pol_mode set, data follow the polarity the sequencer asks for; otherwise raw
  wire logic [95:0] conv_data = pol_mode ? (input_polarity ? rev : norm) : raw;

  adc_chop_standby_detect_ctrl #(.DETECT_TICK_CYCLES(10)) u_adc_chop_standby_detect_ctrl (
    .clock, .rstn, .converter_clock_in, .sync_reset_n, .sclk, .cs_n, .din, .dout,
    .dout_oe_n, .data_ready_n, .chop_enable, .chop_settle_delay, .oversampling_ratio,
    .power_level_select, .dc_test_request, .detect_enable, .threshold_high_reg,
    .threshold_low_reg, .detect_sample_count, .detect_hit_count, .detect_all_channels,
    .channel_enable, .conv_valid, .conv_data, .input_polarity, .filter_reset,
    .chop_result, .result_valid, .phase_cal_enable, .dc_test_select, .power_mode,
    .channel_on, .osc_enable, .device_in_reset
  );
  host_serial_ctrl u_host_serial_ctrl (.clock, .dout, .sclk, .cs_n, .din, .sync_reset_n);

  always #50 clock = ~clock;
  always #400 converter_clock_in = ~converter_clock_in;
  always @(posedge converter_clock_in) ticks++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      chk(1'b0, "wait bound");
      end_of_test();
    end
  endtask

  // Ticks from t0 to the next result, then ready must drop
  task automatic wait_res(input int t0, input int exp);
    int d;
    for (int i = 0; i < 3000; i++) begin
      step(1);
      if (result_valid === 1'b1) begin
        d = ticks - t0;
        chk(d >= exp - 1 && d <= exp + 1, "result timing");
        step(1);
        chk(data_ready_n === 1'b0, "ready after result");
        return;
      end
    end
    tmo(3000, 3000);
  endtask

  // Reference model: every result the design flags is compared here
  always @(negedge clock) begin
    if (filter_reset === 1'b1) fr_cnt++;
    if (result_valid === 1'b1) begin
      if (chop_enable) chk(chop_result === exp_chop, "chop result");
      else if (exp_q.size() > 0) chk(chop_result === exp_q.pop_front(), "plain result");
      else chk(1'b0, "unexpected result");
    end
  end

  initial begin
    for (int c = 0; c < 4; c++) begin
      a = $signed(rnd()) >>> 12;
      o = $signed(rnd()) >>> 16;
      norm[c*24 +: 24] = 24'(a + o);
      rev[c*24 +: 24] = 24'(o - a);
      exp_chop[c*24 +: 24] = 24'(a);
    end
    step(3);
    rstn = 1'b1;
    step(3);
    chk(data_ready_n === 1'b1 && dout_oe_n === 1'b1 && channel_on === 4'hf, "reset");
    chk(power_mode === high_resolution_level && phase_cal_enable === 1'b1, "reset cfg");
    for (int p = 0; p < 4; p++) begin
      power_level_select = 2'(p);
      step(2);
      chk(power_mode === (p == 0 ? 3'h1 : p == 1 ? 3'h2 : 3'h4), "power");
    end
    for (int k = 0; k < 3; k++) begin
      raw = {rnd(), rnd(), rnd()};
      exp_q.push_back(raw);
      conv_valid = 1'b1;
      step(1);
      conv_valid = 1'b0;
      step(1);
      chk(data_ready_n === 1'b0, "plain ready");
      step(6);
    end
    chk(phase_cal_enable === 1'b1 && dc_test_select === 1'b1, "plain cfg");
    pol_mode = 1'b1;
    chop_enable = 1'b1;
    step(2);
    chk(phase_cal_enable === 1'b0 && dc_test_select === 1'b0, "chop cfg");
    n = ticks;
    u_host_serial_ctrl.sync_pulse(5);
    wait_res(n, 82);
    for (int k = 0; k < 2; k++) begin
      fr0 = fr_cnt;
      pol0 = input_polarity;
      wait_res(ticks, 19);
      chk(fr_cnt - fr0 == 1 && input_polarity !== pol0, "swap");
    end
    // Longer delay code rides on the ratio change, which restarts anyway
    chop_settle_delay = 4'h2;
    oversampling_ratio = 15'h0006;
    wait_res(ticks, 96);
    fork
      u_host_serial_ctrl.sync_pulse(30);
      begin
        step(28);
        chk(device_in_reset === 1'b1, "pin reset");
      end
    join
    wait_res(ticks, 96);
    chk(device_in_reset === 1'b0, "reset release");
    wait_res(ticks, 26);
    u_host_serial_ctrl.send_cmd(16'h0022);
    chk(u_host_serial_ctrl.resp === 16'h0001, "run response");
    for (n = 0; n < 20 && channel_on !== 4'h0; n++) step(1);
    tmo(n, 20);
    chop_enable = 1'b0;
    pol_mode = 1'b0;
    raw = {24'h7fffff, 24'h7fffff, 24'h000010, 24'hfffe00};
    chk(power_mode === 3'h4 && osc_enable === 1'b0, "standby");
    u_host_serial_ctrl.sync_pulse(5);
    for (n = 0; n < 30 && osc_enable !== 1'b1; n++) step(1);
    tmo(n, 30);
    chk(channel_on === 4'h3, "detect channels");
    for (n = 0; n < 18 && data_ready_n === 1'b1; n++) step(1);
    chk(n == 18, "early detect");
    for (n = 0; n < 100 && data_ready_n !== 1'b0; n++) step(1);
    tmo(n, 100);
    step(2);
    chk(osc_enable === 1'b0 && channel_on === 4'h0, "back to standby");
    detect_all_channels = 1'b1;
    detect_hit_count = 3'h0;
    u_host_serial_ctrl.sync_pulse(5);
    for (n = 0; n < 1500 && data_ready_n === 1'b1; n++) step(1);
    chk(n == 1500 && osc_enable === 1'b1, "all channels");
    // Weak channel equals the threshold: not above, so still no hit
    threshold_high_reg = 16'h0000;
    threshold_low_reg = 8'h10;
    for (n = 0; n < 40 && data_ready_n === 1'b1; n++) step(1);
    chk(n == 40, "threshold low byte");
    threshold_low_reg = 8'h0f;
    for (n = 0; n < 100 && data_ready_n !== 1'b0; n++) step(1);
    tmo(n, 100);
    detect_enable = 1'b0;
    step(10);
    u_host_serial_ctrl.sync_pulse(5);
    step(40);
    chk(osc_enable === 1'b0 && channel_on === 4'h0, "detect off");
    u_host_serial_ctrl.send_cmd(16'h0033);
    chk(u_host_serial_ctrl.resp === 16'h0002, "standby response");
    for (n = 0; n < 400 && channel_on !== 4'hf; n++) step(1);
    tmo(n, 400);
    chk(n >= 57, "wake settle");
    dc_test_request = 1'b0;
    step(2);
    chk(dc_test_select === 1'b0 && phase_cal_enable === 1'b1, "test request");
    end_of_test();
  end
endmodule
